// file: rtl/pcsr_pkg.sv
// Purpose: shared constants for the time clock register bank
// Assumes: 16-bit management registers, page 4 selected by host
// Notes: time words are ns[15:0], ns[29:16], sec[15:0], sec[31:16]
// What this block does
// [RULE1] writing one to clock halt stops the clock; bit reads zero
// [RULE2] time logic reset clears clock, logic and these registers
// [RULE3] time logic reset holds until host writes it back to zero
// [RULE4] each time data read returns next 16-bit word of selection
// [RULE5] reads past the last available word return zero
// [RULE6] each time data write stores the next 16-bit word
// [RULE7] tx stamp ready bit 11 set while stamp waits; read clears it
// [RULE8] rx stamp ready bit 10 set while stamp waits; read clears it
// [RULE9] trigger complete bit 9 set on notified firing; status read clears
// [RULE10] event stamp ready bit 8 set while event stamp available
// [RULE11] status bits 3..0 are interrupt enables, reset to zero
// [RULE12] status bits 15:12 and 7:4 ignore writes, read zero
// [RULE13] trigger N running flag at bit 2N, error at 2N+1
// [RULE14] running flag set while enabled and not yet complete
// [RULE15] error flag set when armed with time already past
// [RULE16] error flag clears on disable or on re-arming
// [RULE17] error flag set only with trigger notification enabled
// [RULE18] host selects page 4 before accessing this group
// [RULE19] clock run bit starts clock, reads run state, zero ignored
// [RULE20] trigger select field picks trigger for port and enables
// [RULE21] clock sample bit captures time for port reads, self clears
// [RULE22] interrupt raised when any flag and its enable are set
`default_nettype none
package pcsr_pkg;
    localparam logic [2:0]  PAGE_TIME  = 3'h4;
    localparam logic [4:0]  OFF_CTL    = 5'h14;
    localparam logic [4:0]  OFF_TDP    = 5'h15;
    localparam logic [4:0]  OFF_STS    = 5'h16;
    localparam logic [4:0]  OFF_TSTS   = 5'h17;
    localparam int          C_RST      = 0;
    localparam int          C_HALT     = 1;
    localparam int          C_RUN      = 2;
    localparam int          C_STEP     = 3;
    localparam int          C_LDCLK    = 4;
    localparam int          C_RDCLK    = 5;
    localparam int          C_TLOAD    = 6;
    localparam int          C_TREAD    = 7;
    localparam int          C_TEN      = 8;
    localparam int          C_TDIS     = 9;
    localparam int          C_TSEL     = 10;
    localparam int          NOTIFY_BIT = 31;
    localparam int          N_TRIG     = 8;
    localparam logic [2:0]  TDP_WORDS  = 3'h4;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [31:0] SYS_CLK_HZ = 32'h02FA_F080;
    localparam logic [29:0] NS_PER_SEC = 30'h3B9A_CA00;
    localparam logic [29:0] TICK_NS    = 30'(32'h3B9A_CA00 / SYS_CLK_HZ);
endpackage : pcsr_pkg
`default_nettype wire

// file: rtl/pcsr_if.sv
// Purpose: carrier between bank top, time data port and triggers
// Assumes: one clock, driven by the top's modport
// Notes: time values are {sec[31:0], ns[29:0]}
`default_nettype none
interface pcsr_if;
    logic        srst;
    logic        tdp_load;
    logic        tdp_wr;
    logic        tdp_rd;
    logic        tdp_wr_rst;
    logic [63:0] tdp_load_words;
    logic [63:0] tdp_words;
    logic [15:0] tdp_wdata;
    logic [15:0] tdp_rdata;
    logic [2:0]  tdp_wr_cnt;
    logic [61:0] trg_now;
    logic [2:0]  trg_sel;
    logic        trg_arm;
    logic        trg_en;
    logic        trg_dis;
    logic [63:0] trg_arm_words;
    logic [63:0] trg_sel_words;
    logic [15:0] trg_flags;
    logic        trg_fire_notify;
    modport ctl (output srst, tdp_load, tdp_wr, tdp_rd, tdp_wr_rst, tdp_load_words, tdp_wdata,
                 trg_now, trg_sel, trg_arm, trg_en, trg_dis, trg_arm_words,
                 input tdp_words, tdp_rdata, tdp_wr_cnt, trg_sel_words, trg_flags, trg_fire_notify);
    modport tport (input srst, tdp_load, tdp_wr, tdp_rd, tdp_wr_rst, tdp_load_words, tdp_wdata,
                   output tdp_words, tdp_rdata, tdp_wr_cnt);
    modport trig (input srst, trg_now, trg_sel, trg_arm, trg_en, trg_dis, trg_arm_words,
                  output trg_sel_words, trg_flags, trg_fire_notify);
endinterface : pcsr_if
`default_nettype wire

// file: rtl/pcsr_tport.sv
// Purpose: four-word sequencer behind the time data port
// Assumes: load, read and write pulses from the bank top
// Notes: read data is combinational, top registers it
`default_nettype none
module pcsr_tport (
    input wire logic sys_clk,
    input wire logic arst_n,
    pcsr_if.tport    bus
);
    logic [15:0] word_r [4];
    logic [2:0]  rd_ptr_r;
    logic [2:0]  wr_ptr_r;
    logic        rd_left;
    logic        wr_left;
    assign rd_left = rd_ptr_r < pcsr_pkg::TDP_WORDS;
    assign wr_left = wr_ptr_r < pcsr_pkg::TDP_WORDS;
    assign bus.tdp_rdata = rd_left ? word_r[rd_ptr_r[1:0]] : pcsr_pkg::RST_WORD; // [RULE4] [RULE5]
    assign bus.tdp_wr_cnt = wr_ptr_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_ptr_r <= 3'h0;
        end else if (bus.srst || bus.tdp_load) begin
            rd_ptr_r <= 3'h0;
        end else if (bus.tdp_rd && rd_left) begin
            rd_ptr_r <= rd_ptr_r + 3'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= 3'h0;
        end else if (bus.srst || bus.tdp_wr_rst) begin
            wr_ptr_r <= 3'h0;
        end else if (bus.tdp_wr && wr_left) begin
            wr_ptr_r <= wr_ptr_r + 3'h1;
        end
    end
    for (genvar i = 0; i < 4; i++) begin : g_word
        assign bus.tdp_words[16*i +: 16] = word_r[i];
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                word_r[i] <= pcsr_pkg::RST_WORD;
            end else if (bus.srst) begin
                word_r[i] <= pcsr_pkg::RST_WORD;
            end else if (bus.tdp_load) begin
                word_r[i] <= bus.tdp_load_words[16*i +: 16]; // [RULE21]
            end else if (bus.tdp_wr && wr_left && wr_ptr_r[1:0] == 2'(i)) begin
                word_r[i] <= bus.tdp_wdata; // [RULE6]
            end
        end
    end
endmodule : pcsr_tport
`default_nettype wire

// file: rtl/pcsr_trig.sv
// Purpose: eight trigger slots with running and error flags
// Assumes: arm, enable and disable pulses address trg_sel
// Notes: notification enable rides in bit 31 of the words
`default_nettype none
module pcsr_trig (
    input wire logic sys_clk,
    input wire logic arst_n,
    pcsr_if.trig     bus
);
    wire  [63:0] wsel [pcsr_pkg::N_TRIG];
    wire  [15:0] flags_w;
    wire  [7:0]  fire_w;
    assign bus.trg_sel_words = wsel[bus.trg_sel];
    assign bus.trg_flags = flags_w;
    assign bus.trg_fire_notify = |fire_w;
    for (genvar i = 0; i < pcsr_pkg::N_TRIG; i++) begin : g_trig
        logic [61:0] fire_r;
        logic        note_r;
        logic        run_r;
        logic        err_r;
        logic        hit;
        logic        arm;
        logic        en;
        logic        dis;
        logic        note_u;
        logic        late;
        logic [61:0] fire_u;
        assign hit = bus.trg_sel == 3'(i); // [RULE20]
        assign arm = bus.trg_arm && hit;
        assign en = bus.trg_en && hit;
        assign dis = bus.trg_dis && hit;
        assign fire_u = arm ? {bus.trg_arm_words[63:32], bus.trg_arm_words[29:0]} : fire_r;
        assign note_u = arm ? bus.trg_arm_words[pcsr_pkg::NOTIFY_BIT] : note_r;
        assign late = fire_u < bus.trg_now; // [RULE15]
        assign fire_w[i] = run_r && note_r && (bus.trg_now >= fire_r);
        assign wsel[i] = {fire_r[61:30], note_r, 1'b0, fire_r[29:0]};
        assign flags_w[2*i +: 2] = {err_r, run_r}; // [RULE13]
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                fire_r <= '0;
                note_r <= 1'b0;
            end else if (bus.srst) begin
                fire_r <= '0;
                note_r <= 1'b0;
            end else if (arm) begin
                fire_r <= fire_u;
                note_r <= note_u;
            end
        end
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                run_r <= 1'b0;
                err_r <= 1'b0;
            end else if (bus.srst) begin
                run_r <= 1'b0;
                err_r <= 1'b0;
            end else if (en) begin
                run_r <= !late; // [RULE14]
                err_r <= late && note_u; // [RULE17]
            end else if (dis || arm) begin
                run_r <= 1'b0;
                err_r <= 1'b0; // [RULE16]
            end else if (bus.trg_now >= fire_r) begin
                run_r <= 1'b0; // [RULE14]
            end
        end
        late_err_a: assert property (@(posedge sys_clk) disable iff (!arst_n || bus.srst) // [RULE15]
            en && late && note_u |=> err_r && !run_r) else $error("past arm did not flag error");
    end
endmodule : pcsr_trig
`default_nettype wire

// file: rtl/pcsr_top.sv
// Purpose: time clock control, status and trigger register bank
// Assumes: management front end gives one-cycle rd/wr strobes
// Notes: read data appears one cycle after the read strobe
`default_nettype none
module pcsr_top (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [2:0]  page_sel,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        tx_ts_avail,
    input  wire logic        tx_ts_taken,
    input  wire logic        rx_ts_avail,
    input  wire logic        rx_ts_taken,
    input  wire logic        ev_ts_avail,
    input  wire logic        ev_ts_taken,
    output logic [15:0]      reg_rdata,
    output logic             reg_rvalid,
    output logic             time_irq,
    output logic             clock_running,
    output logic             time_logic_held
);
    pcsr_if bus ();

    pcsr_tport u_tport (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .bus     (bus.tport)
    );

    pcsr_trig u_trig (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .bus     (bus.trig)
    );

    // time sum with nanosecond wrap into seconds
    function automatic logic [61:0] t_add(
        input logic [61:0] a,
        input logic [61:0] b
    );
        logic [30:0] ns;
        logic        cy;
        logic [31:0] sec;
        ns = {1'b0, a[29:0]} + {1'b0, b[29:0]};
        cy = ns >= {1'b0, pcsr_pkg::NS_PER_SEC};
        if (cy) begin
            ns = ns - {1'b0, pcsr_pkg::NS_PER_SEC};
        end
        sec = a[61:30] + b[61:30] + {31'h0, cy};
        return {sec, ns[29:0]};
    endfunction : t_add

    logic        time_reset_r;
    logic        run_r;
    logic        tload_r;
    logic [2:0]  tsel_r;
    logic [61:0] now_r;
    logic [3:0]  ie_r;
    logic        txr_r;
    logic        rxr_r;
    logic        tdn_r;
    logic        evr_r;
    logic [15:0] rdata_r;
    logic        rvalid_r;
    logic        irq_r;
    logic [2:0]  rdn_r;

    // address decode
    logic        pg_ok;
    logic        live;
    logic        hit_ctl;
    logic        hit_tdp;
    logic        hit_sts;
    logic        hit_tsts;
    logic        wr_ctl;
    logic        wr_tdp;
    logic        wr_sts;
    logic        rd_tdp;
    logic        rd_sts;
    logic [15:0] cmd;

    assign pg_ok = page_sel == pcsr_pkg::PAGE_TIME; // [RULE18]
    assign live = !time_reset_r;
    assign hit_ctl = pg_ok && (reg_addr == pcsr_pkg::OFF_CTL);
    assign hit_tdp = pg_ok && (reg_addr == pcsr_pkg::OFF_TDP);
    assign hit_sts = pg_ok && (reg_addr == pcsr_pkg::OFF_STS);
    assign hit_tsts = pg_ok && (reg_addr == pcsr_pkg::OFF_TSTS);
    assign wr_ctl = reg_wr && hit_ctl;
    assign wr_tdp = reg_wr && hit_tdp && live;
    assign wr_sts = reg_wr && hit_sts && live;
    assign rd_tdp = reg_rd && hit_tdp && live;
    assign rd_sts = reg_rd && hit_sts && live;
    // command bits only act while the time logic is released
    assign cmd = (wr_ctl && live) ? reg_wdata : pcsr_pkg::RST_WORD; // [RULE3]

    // time clock
    logic [61:0] wr_t;
    logic [61:0] tick_t;
    logic [61:0] step_t;
    logic [61:0] now_nxt;
    logic        run_nxt;

    assign wr_t = {bus.tdp_words[63:32], bus.tdp_words[29:0]};
    assign tick_t = t_add(now_r, {32'h0000_0000, pcsr_pkg::TICK_NS});
    assign step_t = t_add(now_r, wr_t);
    // a step or load replaces that cycle's tick
    assign now_nxt = cmd[pcsr_pkg::C_LDCLK] ? wr_t
                   : cmd[pcsr_pkg::C_STEP]  ? step_t
                   : run_r                  ? tick_t
                   : now_r;
    assign run_nxt = cmd[pcsr_pkg::C_HALT] ? 1'b0 // [RULE1]
                   : cmd[pcsr_pkg::C_RUN]  ? 1'b1 // [RULE19]
                   : run_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            time_reset_r <= 1'b0;
        end else if (wr_ctl) begin
            time_reset_r <= reg_wdata[pcsr_pkg::C_RST]; // [RULE3]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            now_r <= '0;
            run_r <= 1'b0;
        end else if (time_reset_r) begin
            now_r <= '0; // [RULE2]
            run_r <= 1'b0;
        end else begin
            now_r <= now_nxt;
            run_r <= run_nxt;
        end
    end

    // trigger control
    logic [2:0]  sel_now;
    logic        tl_done;
    logic        tload_nxt;

    assign sel_now = wr_ctl ? reg_wdata[pcsr_pkg::C_TSEL +: 3] : tsel_r; // [RULE20]
    assign tl_done = tload_r && (cmd[pcsr_pkg::C_TEN] || bus.tdp_wr_cnt == pcsr_pkg::TDP_WORDS);
    assign tload_nxt = cmd[pcsr_pkg::C_TLOAD] ? 1'b1
                     : tl_done               ? 1'b0
                     : tload_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tload_r <= 1'b0;
            tsel_r <= 3'h0;
        end else if (time_reset_r) begin
            tload_r <= 1'b0;
            tsel_r <= 3'h0;
        end else begin
            tload_r <= tload_nxt;
            tsel_r <= sel_now;
        end
    end

    assign bus.srst = time_reset_r; // [RULE2]
    assign bus.trg_now = now_r;
    assign bus.trg_sel = sel_now;
    assign bus.trg_arm = tl_done;
    assign bus.trg_arm_words = bus.tdp_words;
    assign bus.trg_en = cmd[pcsr_pkg::C_TEN];
    // loading a trigger first takes it out of service
    assign bus.trg_dis = cmd[pcsr_pkg::C_TDIS] || cmd[pcsr_pkg::C_TLOAD];

    // time data port sequencing
    assign bus.tdp_rd = rd_tdp; // [RULE4]
    assign bus.tdp_wr = wr_tdp; // [RULE6]
    assign bus.tdp_wdata = reg_wdata;
    assign bus.tdp_wr_rst = cmd[pcsr_pkg::C_TLOAD] || tl_done
                         || cmd[pcsr_pkg::C_LDCLK] || cmd[pcsr_pkg::C_STEP];
    assign bus.tdp_load = cmd[pcsr_pkg::C_RDCLK] || cmd[pcsr_pkg::C_TREAD]; // [RULE21]
    assign bus.tdp_load_words = cmd[pcsr_pkg::C_TREAD] ? bus.trg_sel_words
                              : {now_r[61:30], 2'b00, now_r[29:0]};

    // status flags and enables
    logic        txr_nxt;
    logic        rxr_nxt;
    logic        tdn_nxt;
    logic        evr_nxt;
    logic [3:0]  flags4;

    assign txr_nxt = tx_ts_avail || (txr_r && !tx_ts_taken); // [RULE7]
    assign rxr_nxt = rx_ts_avail || (rxr_r && !rx_ts_taken); // [RULE8]
    assign tdn_nxt = bus.trg_fire_notify || (tdn_r && !rd_sts); // [RULE9]
    assign evr_nxt = ev_ts_avail || (evr_r && !ev_ts_taken); // [RULE10]
    assign flags4 = {txr_r, rxr_r, tdn_r, evr_r};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txr_r <= 1'b0;
            rxr_r <= 1'b0;
            tdn_r <= 1'b0;
            evr_r <= 1'b0;
        end else if (time_reset_r) begin
            txr_r <= 1'b0;
            rxr_r <= 1'b0;
            tdn_r <= 1'b0;
            evr_r <= 1'b0;
        end else begin
            txr_r <= txr_nxt;
            rxr_r <= rxr_nxt;
            tdn_r <= tdn_nxt;
            evr_r <= evr_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ie_r <= 4'h0;
        end else if (time_reset_r) begin
            ie_r <= 4'h0;
        end else if (wr_sts) begin
            ie_r <= reg_wdata[3:0]; // [RULE11]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flags4 & ie_r); // [RULE22]
        end
    end

    // read data
    logic [15:0] ctl_rd;
    logic [15:0] sts_rd;
    logic [15:0] rd_nxt;

    // halt, enable, disable and sample strobes read as zero
    assign ctl_rd = {3'h0, tsel_r, 3'h0, tload_r, 3'h0, run_r, 1'b0, time_reset_r}; // [RULE1] [RULE19]
    assign sts_rd = {4'h0, flags4, 4'h0, ie_r}; // [RULE12]
    assign rd_nxt = hit_ctl  ? ctl_rd
                  : hit_tdp  ? bus.tdp_rdata
                  : hit_sts  ? sts_rd
                  : hit_tsts ? bus.trg_flags // [RULE13]
                  : pcsr_pkg::RST_WORD;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= pcsr_pkg::RST_WORD;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rd_nxt;
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign time_irq = irq_r;
    assign clock_running = run_r;
    assign time_logic_held = time_reset_r;

    // reads taken since the port was last loaded, checks only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdn_r <= 3'h0;
        end else if (bus.tdp_load || time_reset_r) begin
            rdn_r <= 3'h0;
        end else if (rd_tdp && rdn_r != pcsr_pkg::TDP_WORDS) begin
            rdn_r <= rdn_r + 3'h1;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence halt_wr_s;
        wr_ctl && live && reg_wdata[pcsr_pkg::C_HALT];
    endsequence

    sequence run_wr_s;
        wr_ctl && live && reg_wdata[pcsr_pkg::C_RUN] && !reg_wdata[pcsr_pkg::C_HALT];
    endsequence

    sequence ctl_read_s;
        reg_rd && hit_ctl ##1 rvalid_r;
    endsequence

    halt_stops_a: assert property (halt_wr_s |=> !run_r ##1 now_r == $past(now_r)) // [RULE1]
        else $error("halt did not freeze the clock");

    halt_zero_a: assert property (ctl_read_s |-> !reg_rdata[pcsr_pkg::C_HALT] && !reg_rdata[9]) // [RULE1]
        else $error("self clearing bits read nonzero");

    run_starts_a: assert property (run_wr_s |=> run_r ##1 now_r != $past(now_r)) // [RULE19]
        else $error("run bit did not start the clock");

    reset_clears_a: assert property (time_reset_r |=> now_r == '0 && ie_r == 4'h0 && !run_r) // [RULE2]
        else $error("time logic reset left state");

    reset_holds_a: assert property (time_reset_r && !wr_ctl |=> time_reset_r) // [RULE3]
        else $error("time logic reset cleared itself");

    past_end_zero_a: assert property (rd_tdp && rdn_r == pcsr_pkg::TDP_WORDS |=> reg_rdata == 16'h0000) // [RULE5]
        else $error("read past last word not zero");

    sample_first_a: assert property (cmd[pcsr_pkg::C_RDCLK] ##2 rd_tdp // [RULE21]
        |=> reg_rdata == $past(now_r[15:0], 3))
        else $error("sampled time not returned");

    tx_ready_a: assert property (tx_ts_avail && live |=> txr_r) // [RULE7]
        else $error("tx stamp ready not set");

    done_set_wins_a: assert property (bus.trg_fire_notify && live |=> tdn_r) // [RULE9]
        else $error("trigger complete lost");

    done_cor_a: assert property (rd_sts && !bus.trg_fire_notify |=> !tdn_r) // [RULE9]
        else $error("trigger complete not cleared on read");

    ie_write_a: assert property (wr_sts |=> ie_r == $past(reg_wdata[3:0])) // [RULE11]
        else $error("interrupt enables not stored");

    sts_resv_a: assert property (reg_rd && hit_sts |=> reg_rdata[15:12] == 4'h0 && reg_rdata[7:4] == 4'h0) // [RULE12]
        else $error("reserved status bits nonzero");

    irq_follow_a: assert property (##1 time_irq == $past(|(flags4 & ie_r))) // [RULE22]
        else $error("interrupt does not follow flags");
endmodule : pcsr_top
`default_nettype wire

// file: verification/pcsr_host.sv
// Purpose: management host model issuing page 4 register accesses
// Assumes: block answers a read one cycle after the strobe
// Notes: write data shows the inverse of the last value when idle
`default_nettype none
module pcsr_host (
    input  wire logic        sys_clk,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid,
    output logic [2:0]       page_sel,
    output logic [4:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] page = 3'h4;
    assign page_sel = page;
    initial begin
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
        // idle edge keeps back-to-back strobes apart
        @(posedge sys_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        for (int i = 0; i < 3 && reg_rvalid !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        ok = reg_rvalid;
        d = reg_rdata;
        @(posedge sys_clk);
        #1;
    endtask : rd
endmodule : pcsr_host
`default_nettype wire

// file: verification/testbench.sv
// Purpose: self-checking bench for the time clock register bank
// Assumes: host model makes every register access
// Notes: expected words and flags come from integer models
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [2:0]  page_sel, av = 3'h0, tk = 3'h0;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v, d;
    logic        reg_wr, reg_rd, reg_rvalid, time_irq, clock_running, time_logic_held, ok;
    logic [15:0] q[$];
    logic [31:0] ns, sec;
    int          failures = 0, n_checks = 0, seed = 32'h39fc;
    int          fb[3] = '{11, 10, 8}, eb[3] = '{3, 2, 0};
    pcsr_top dut_u (.sys_clk, .arst_n, .page_sel, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .tx_ts_avail(av[0]), .tx_ts_taken(tk[0]), .rx_ts_avail(av[1]), .rx_ts_taken(tk[1]),
        .ev_ts_avail(av[2]), .ev_ts_taken(tk[2]), .reg_rdata, .reg_rvalid, .time_irq,
        .clock_running, .time_logic_held);
    pcsr_host host_u (.sys_clk, .reg_rdata, .reg_rvalid, .page_sel, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] exp);
        host_u.rd(a, v, ok);
        chk("rvalid", {15'h0000, ok}, 16'h0001);
        if (ok !== 1'b1) tally_and_finish();
        chk(nm, v, exp);
    endtask : rchk
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt
    task automatic put4(input logic [31:0] n, input logic [31:0] s, input logic nf);
        q = '{n[15:0], {nf, 1'b0, n[29:16]}, s[15:0], s[31:16]};
        foreach (q[i]) host_u.wr(5'h15, q[i]);
    endtask : put4
    task automatic arm(input logic [2:0] t, input logic [31:0] n, input logic nf, input logic en);
        host_u.wr(5'h14, {3'h0, t, 10'h040});
        put4(n, sec, nf);
        if (en) host_u.wr(5'h14, {3'h0, t, 10'h100});
        wt(2);
    endtask : arm
    initial begin
        wt(20);
        arst_n = 1'b1;
        wt(1);
        rchk("sts", 5'h16, 16'h0000);
        rchk("tsts", 5'h17, 16'h0000);
        d = 16'($random(seed));
        host_u.wr(5'h16, d);
        rchk("sts_rw", 5'h16, d & 16'h000f);
        for (int i = 0; i < 3; i++) begin
            host_u.wr(5'h16, 16'h0001 << eb[i]);
            av[i] = 1'b1;
            wt(1);
            av[i] = 1'b0;
            wt(3);
            chk("irq", {15'h0000, time_irq}, 16'h0001);
            rchk("rdy", 5'h16, (16'h0001 << fb[i]) | (16'h0001 << eb[i]));
            tk[i] = 1'b1;
            wt(1);
            tk[i] = 1'b0;
            wt(3);
            chk("irq_off", {15'h0000, time_irq}, 16'h0000);
            rchk("clr", 5'h16, 16'h0001 << eb[i]);
        end
        ns = 32'h0123_4567;
        sec = 32'($random(seed)) | 32'h0000_0001;
        put4(ns, sec, 1'b0);
        host_u.wr(5'h14, 16'h0010);
        host_u.wr(5'h14, 16'h0020);
        foreach (q[i]) rchk("tdp", 5'h15, q[i]);
        rchk("tdp_end", 5'h15, 16'h0000);
        arm(3'h2, 32'h0000_0000, 1'b0, 1'b1);
        host_u.rd(5'h17, v, ok);
        chk("err_quiet", v & 16'h0020, 16'h0000);
        rchk("done_gate", 5'h16, 16'h0001);
        host_u.wr(5'h14, 16'h0a00);
        arm(3'h3, 32'h0000_0000, 1'b1, 1'b1);
        rchk("err", 5'h17, 16'h0080);
        arm(3'h3, 32'h0000_0000, 1'b1, 1'b0);
        rchk("rearm", 5'h17, 16'h0000);
        host_u.wr(5'h14, 16'h0d00);
        rchk("err2", 5'h17, 16'h0080);
        host_u.wr(5'h14, 16'h0e00);
        rchk("dis", 5'h17, 16'h0000);
        host_u.rd(5'h16, v, ok);
        arm(3'h5, ns + 32'h0000_0190, 1'b1, 1'b1);
        rchk("active", 5'h17, 16'h0400);
        host_u.wr(5'h14, 16'h1480);
        foreach (q[i]) rchk("trd", 5'h15, q[i]);
        host_u.wr(5'h14, 16'h0004);
        wt(2);
        chk("running", {15'h0000, clock_running}, 16'h0001);
        rchk("ctl_run", 5'h14, 16'h0004);
        for (int k = 0; k < 60 && v !== 16'h0000; k++) host_u.rd(5'h17, v, ok);
        chk("fired", v, 16'h0000);
        if (v !== 16'h0000) tally_and_finish();
        rchk("done", 5'h16, 16'h0201);
        rchk("done_cor", 5'h16, 16'h0001);
        host_u.wr(5'h14, 16'h0000);
        wt(2);
        chk("run_zero", {15'h0000, clock_running}, 16'h0001);
        host_u.wr(5'h14, 16'h0002);
        wt(2);
        chk("halted", {15'h0000, clock_running}, 16'h0000);
        rchk("ctl_halt", 5'h14, 16'h0000);
        put4(ns, sec, 1'b0);
        host_u.wr(5'h14, 16'h0010);
        put4(32'h0000_0190, 32'h0000_0000, 1'b0);
        host_u.wr(5'h14, 16'h0008);
        host_u.wr(5'h14, 16'h0020);
        rchk("step", 5'h15, ns[15:0] + 16'h0190);
        host_u.page = 3'h3;
        rchk("off_page", 5'h16, 16'h0000);
        host_u.page = 3'h4;
        host_u.wr(5'h14, 16'h0004);
        host_u.wr(5'h14, 16'h0001);
        host_u.wr(5'h16, 16'h000f);
        wt(6);
        chk("held", {15'h0000, time_logic_held}, 16'h0001);
        chk("rst_stop", {15'h0000, clock_running}, 16'h0000);
        rchk("rst_sts", 5'h16, 16'h0000);
        host_u.wr(5'h14, 16'h0000);
        wt(2);
        chk("released", {15'h0000, time_logic_held}, 16'h0000);
        rchk("post_sts", 5'h16, 16'h0000);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
